/* File: src/rcp_pkg.sv */
// Package of constants and types for the remote control port
package rcp_pkg;
   // ==========================================================
   // Timing
   // ==========================================================
   localparam int unsigned RCP_CLK_HZ       = 200_000_000;
   localparam int unsigned RCP_QUAL_TIME_MS = 50;
   // Least time with truncating division; 10_000_000 cycles at 200 MHz
   localparam int unsigned RCP_QUAL_CYCLES  =
      (RCP_QUAL_TIME_MS * (RCP_CLK_HZ / 1000) + 0);
   localparam int unsigned RCP_CNT_W        = 24;
   // ==========================================================
   // Input layout and reset values
   // ==========================================================
   localparam int unsigned RCP_NUM_IN  = 6;
   localparam int unsigned RCP_IN_CANCEL = 0;   // Also area select bit 0
   localparam int unsigned RCP_IN_ENTER  = 1;   // Also area select bit 1
   localparam int unsigned RCP_IN_NEXT   = 2;   // Also area select bit 2
   localparam int unsigned RCP_IN_VERIFY = 3;
   localparam int unsigned RCP_IN_START  = 4;
   localparam int unsigned RCP_IN_CLEAR  = 5;
   localparam logic        RCP_IN_IDLE   = 1'b1; // Pulled-up, inactive level
   localparam logic [2:0]  RCP_AREA_RST  = 3'h0;

   // Port operating mode
   typedef enum logic {
      RCP_MODE_STANDARD = 1'b0,
      RCP_MODE_BANK     = 1'b1
   } rcp_mode_t;
endpackage : rcp_pkg

/* File: src/rcp_qualifier.sv */
// Synchroniser and stability filter for one active-low remote input
`timescale 1ns/100ps
`default_nettype none
module rcp_qualifier
   import rcp_pkg::*;
#(
   parameter int unsigned QUAL_CYCLES = rcp_pkg::RCP_QUAL_CYCLES
) (
   input  wire logic mclk_i,
   input  wire logic rstn_i,
   input  wire logic raw_n_i,
   output logic      level_n_o
);
   // ==========================================================
   // State
   // ==========================================================
   logic                 sync1_reg, sync1_next;
   logic                 sync2_reg, sync2_next;
   logic                 level_reg, level_next;
   logic [RCP_CNT_W-1:0] cnt_reg,   cnt_next;

   // Counter restarts whenever the synced level agrees with the output
   always_comb begin
      sync1_next = raw_n_i;
      sync2_next = sync1_reg;
      level_next = level_reg;
      cnt_next   = '0;
      if (sync2_reg != level_reg) begin
         if (cnt_reg >= RCP_CNT_W'(QUAL_CYCLES - 1)) begin
            level_next = sync2_reg;
         end else begin
            cnt_next = cnt_reg + 1'b1;
         end
      end
   end

   // Registers; reset to the pulled-up idle level
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync1_reg <= RCP_IN_IDLE;
         sync2_reg <= RCP_IN_IDLE;
         level_reg <= RCP_IN_IDLE;
         cnt_reg   <= '0;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
         level_reg <= level_next;
         cnt_reg   <= cnt_next;
      end
   end

   assign level_n_o = level_reg;
endmodule : rcp_qualifier
`default_nettype wire

/* File: src/rcp_remote_port.sv */
// Remote control port: input qualification, mode decode and status outputs
// What this block does
// - Connection-present output stays high whenever powered and out of reset.
// - Busy output follows busy indicator as a steady, never blinking level.
// - Pass output is high while pass indicator is lit and clear is not asserted.
// - Error output is high while error indicator is lit and clear is not asserted.
// - Inputs count as asserted only after holding active level 50 ms.
// - A stored setting selects standard mode or bank mode.
// - Standard mode: three shared inputs act as cancel, enter, next buttons.
// - Bank mode: shared inputs form area number, cancel bit0 to next bit2.
// - Bank mode disables the front-panel command menu.
// - Area select lines: low level reads 0, high level reads 1.
// - Qualified low verify input starts an independent verify.
// - Qualified low start input launches the automatic procedure.
// - Qualified low clear input drops pass and error outputs.
`timescale 1ns/100ps
`default_nettype none
module rcp_remote_port
   import rcp_pkg::*;
#(
   parameter int unsigned QUAL_CYCLES = rcp_pkg::RCP_QUAL_CYCLES
) (
   input  wire logic               mclk_i,
   input  wire logic               rstn_i,
   // Remote connector inputs, active low
   input  wire logic               cancel_n_i,
   input  wire logic               enter_n_i,
   input  wire logic               next_n_i,
   input  wire logic               verify_request_n_i,
   input  wire logic               start_n_i,
   input  wire logic               result_clear_n_i,
   // Stored configuration
   input  wire rcp_pkg::rcp_mode_t mode_i,
   // Internal status indicators
   input  wire logic               busy_ind_i,
   input  wire logic               pass_set_i,
   input  wire logic               error_set_i,
   // Remote connector outputs, active high
   output logic                    link_present_o,
   output logic                    busy_o,
   output logic                    pass_o,
   output logic                    error_o,
   // Towards programmer core
   output logic                    btn_cancel_o,
   output logic                    btn_enter_o,
   output logic                    btn_next_o,
   output logic                    menu_enable_o,
   output logic [2:0]              area_sel_o,
   output logic                    verify_start_o,
   output logic                    auto_start_o
);
   // ==========================================================
   // Input qualification
   // ==========================================================
   logic [RCP_NUM_IN-1:0] raw_n;
   logic [RCP_NUM_IN-1:0] qual_n;

   assign raw_n[RCP_IN_CANCEL] = cancel_n_i;
   assign raw_n[RCP_IN_ENTER]  = enter_n_i;
   assign raw_n[RCP_IN_NEXT]   = next_n_i;
   assign raw_n[RCP_IN_VERIFY] = verify_request_n_i;
   assign raw_n[RCP_IN_START]  = start_n_i;
   assign raw_n[RCP_IN_CLEAR]  = result_clear_n_i;

   for (genvar g = 0; g < RCP_NUM_IN; g++) begin : g_qual
      rcp_qualifier #(
         .QUAL_CYCLES (QUAL_CYCLES)
      ) u_qual (
         .mclk_i    (mclk_i),
         .rstn_i    (rstn_i),
         .raw_n_i   (raw_n[g]),
         .level_n_o (qual_n[g])
      );
   end

   // ==========================================================
   // Mode decode
   // ==========================================================
   // Standard mode test, shared by the button, menu and area logic
   function automatic logic is_standard(input rcp_mode_t mode);
      return (mode == RCP_MODE_STANDARD);
   endfunction

   // ==========================================================
   // Status outputs
   // ==========================================================
   logic       busy_reg,   busy_next;
   logic       pass_reg,   pass_next;
   logic       error_reg,  error_next;

   // Clear is a level override, so results come back once it lifts
   always_comb begin
      busy_next  = busy_ind_i;
      pass_next  = pass_set_i;
      error_next = error_set_i;
      if (!qual_n[RCP_IN_CLEAR]) begin
         pass_next  = 1'b0;
         error_next = 1'b0;
      end
   end

   // Registers of the status group
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         busy_reg  <= 1'b0;
         pass_reg  <= 1'b0;
         error_reg <= 1'b0;
      end else begin
         busy_reg  <= busy_next;
         pass_reg  <= pass_next;
         error_reg <= error_next;
      end
   end

   // ==========================================================
   // Shared inputs: buttons, menu and area select
   // ==========================================================
   logic [2:0] btn_reg,    btn_next;
   logic       menu_reg,   menu_next;
   logic [2:0] area_reg,   area_next;

   // Area keeps its last bank value in standard mode, so a mode flip cannot glitch it
   always_comb begin
      btn_next  = is_standard(mode_i) ? ~qual_n[2:0] : 3'h0;
      menu_next = is_standard(mode_i);
      area_next = area_reg;
      if (!is_standard(mode_i)) begin
         area_next = {qual_n[RCP_IN_NEXT], qual_n[RCP_IN_ENTER], qual_n[RCP_IN_CANCEL]};
      end
   end

   // Registers of the shared-input group
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         btn_reg  <= 3'h0;
         menu_reg <= 1'b1;
         area_reg <= RCP_AREA_RST;
      end else begin
         btn_reg  <= btn_next;
         menu_reg <= menu_next;
         area_reg <= area_next;
      end
   end

   // ==========================================================
   // Command events
   // ==========================================================
   logic       ver_reg,    ver_next;
   logic       auto_reg,   auto_next;
   logic       vprev_reg,  vprev_next;
   logic       sprev_reg,  sprev_next;

   // One pulse per qualified falling edge; a held line never repeats the command
   always_comb begin
      vprev_next = qual_n[RCP_IN_VERIFY];
      sprev_next = qual_n[RCP_IN_START];
      ver_next   = vprev_reg & ~qual_n[RCP_IN_VERIFY];
      auto_next  = sprev_reg & ~qual_n[RCP_IN_START];
   end

   // Registers of the event group; history starts idle so reset gives no false edge
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ver_reg   <= 1'b0;
         auto_reg  <= 1'b0;
         vprev_reg <= RCP_IN_IDLE;
         sprev_reg <= RCP_IN_IDLE;
      end else begin
         ver_reg   <= ver_next;
         auto_reg  <= auto_next;
         vprev_reg <= vprev_next;
         sprev_reg <= sprev_next;
      end
   end

   // Connection flag: held while out of reset, so power-up glitches stay low
   logic link_reg;
   logic link_next;
   always_comb begin
      link_next = 1'b1;
   end
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         link_reg <= 1'b0;
      end else begin
         link_reg <= link_next;
      end
   end

   assign link_present_o = link_reg;
   assign busy_o         = busy_reg;
   assign pass_o         = pass_reg;
   assign error_o        = error_reg;
   assign btn_cancel_o   = btn_reg[RCP_IN_CANCEL];
   assign btn_enter_o    = btn_reg[RCP_IN_ENTER];
   assign btn_next_o     = btn_reg[RCP_IN_NEXT];
   assign menu_enable_o  = menu_reg;
   assign area_sel_o     = area_reg;
   assign verify_start_o = ver_reg;
   assign auto_start_o   = auto_reg;
endmodule : rcp_remote_port
`default_nettype wire

/* File: verif/rcp_remote_port_sva.sv */
// Checker of the remote control port outputs
`timescale 1ns/100ps
`default_nettype none
module rcp_remote_port_chk
   import rcp_pkg::*;
#(
   parameter int unsigned QUAL_CYCLES = 8
) (
   input wire logic               mclk_i,
   input wire logic               rstn_i,
   input wire logic               verify_request_n_i,
   input wire logic               start_n_i,
   input wire logic               result_clear_n_i,
   input wire rcp_pkg::rcp_mode_t mode_i,
   input wire logic               busy_ind_i,
   input wire logic               pass_set_i,
   input wire logic               error_set_i,
   input wire logic               link_present_o,
   input wire logic               busy_o,
   input wire logic               pass_o,
   input wire logic               error_o,
   input wire logic               btn_cancel_o,
   input wire logic               btn_enter_o,
   input wire logic               btn_next_o,
   input wire logic               menu_enable_o,
   input wire logic               verify_start_o,
   input wire logic               auto_start_o
);
   // ==========
   // Properties; depths below assume QUAL_CYCLES of 6 to 9
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   sequence clr_held;
      (!result_clear_n_i)[*8] ##1 (!result_clear_n_i)[*5];
   endsequence
   sequence in_bank;
      (mode_i == RCP_MODE_BANK)[*2];
   endsequence
   a_link_always: assert property (1 |=> link_present_o)
      else $error("link present dropped");
   a_busy_steady: assert property (1 |=> busy_o == $past(busy_ind_i))
      else $error("busy does not follow indicator");
   a_pass_cause: assert property (pass_o |-> $past(pass_set_i))
      else $error("pass without indicator");
   a_error_cause: assert property (error_o |-> $past(error_set_i))
      else $error("error without indicator");
   a_clear_drops: assert property (clr_held |-> !pass_o && !error_o)
      else $error("clear did not drop results");
   a_verify_pulse: assert property ($rose(verify_start_o) |->
      (!$past(verify_request_n_i, 4) && !$past(verify_request_n_i, 9)) ##1 !verify_start_o)
      else $error("bad verify pulse");
   a_start_pulse: assert property ($rose(auto_start_o) |->
      (!$past(start_n_i, 4) && !$past(start_n_i, 9)) ##1 !auto_start_o)
      else $error("bad start pulse");
   a_menu_mode: assert property (1 |=> menu_enable_o == ($past(mode_i) == RCP_MODE_STANDARD))
      else $error("menu enable wrong for mode");
   a_bank_no_btn: assert property (in_bank |-> !btn_cancel_o && !btn_enter_o && !btn_next_o)
      else $error("button active in bank mode");
endmodule // rcp_remote_port_chk
bind rcp_remote_port rcp_remote_port_chk #(.QUAL_CYCLES(QUAL_CYCLES)) u_chk (
   .mclk_i(mclk_i), .rstn_i(rstn_i), .verify_request_n_i(verify_request_n_i), .start_n_i(start_n_i),
   .result_clear_n_i(result_clear_n_i), .mode_i(mode_i), .busy_ind_i(busy_ind_i), .pass_set_i(pass_set_i),
   .error_set_i(error_set_i), .link_present_o(link_present_o), .busy_o(busy_o), .pass_o(pass_o),
   .error_o(error_o), .btn_cancel_o(btn_cancel_o), .btn_enter_o(btn_enter_o), .btn_next_o(btn_next_o),
   .menu_enable_o(menu_enable_o), .verify_start_o(verify_start_o), .auto_start_o(auto_start_o));
`default_nettype wire

/* File: verif/rcp_remote_ctrl.sv */
// External controller model driving the active-low remote lines
`timescale 1ns/100ps
`default_nettype none
module rcp_remote_ctrl #(
   parameter int HOLD = 8
) (
   input  wire logic       mclk_i,
   input  wire logic [5:0] want_i,
   output wire logic [5:0] line_n_o
);
   // ==========
   // Line driver
   int         held  = 0;
   logic [5:0] lines = 6'h3F;   // Idle high like the pull-ups
   assign line_n_o = lines;
   always @(posedge mclk_i) begin
      if (held < HOLD) begin
         held <= held + 1;
      end else if (lines !== ~want_i) begin
         lines <= #0.5 ~want_i;   // Changes 0.5 ns after the edge, no sooner than HOLD+1 cycles after the last change
         held  <= 0;
      end
   end
endmodule // rcp_remote_ctrl
`default_nettype wire

/* File: verif/rcp_remote_port_tb.sv */
// Testbench of the remote control port
`timescale 1ns/100ps
`default_nettype none
module rcp_remote_port_tb;
   import rcp_pkg::*;
   // ==========
   // Signals and instances
   localparam int unsigned QC = 8;   // Short qualification keeps the run brief
   logic       mclk_i = 1'b0;
   logic       rstn_i = 1'b0;
   logic [5:0] want   = 6'h00;
   logic [5:0] line_n;
   rcp_mode_t  mode   = RCP_MODE_STANDARD;
   logic       busy_ind = 1'b0, pass_set = 1'b0, error_set = 1'b0;
   logic       link, busy, pass, err, bc, be, bn, menu, vs, as;
   logic [2:0] area;
   int         errors = 0;
   int         samples_checked = 0;
   always #2.5 mclk_i = ~mclk_i;
   rcp_remote_ctrl #(.HOLD(QC)) u_rcp_remote_ctrl (.mclk_i(mclk_i), .want_i(want), .line_n_o(line_n));
   rcp_remote_port #(.QUAL_CYCLES(QC)) u_rcp_remote_port (.mclk_i(mclk_i), .rstn_i(rstn_i),
      .cancel_n_i(line_n[0]), .enter_n_i(line_n[1]), .next_n_i(line_n[2]), .verify_request_n_i(line_n[3]),
      .start_n_i(line_n[4]), .result_clear_n_i(line_n[5]), .mode_i(mode), .busy_ind_i(busy_ind),
      .pass_set_i(pass_set), .error_set_i(error_set), .link_present_o(link), .busy_o(busy), .pass_o(pass),
      .error_o(err), .btn_cancel_o(bc), .btn_enter_o(be), .btn_next_o(bn), .menu_enable_o(menu),
      .area_sel_o(area), .verify_start_o(vs), .auto_start_o(as));
   // ==========
   // Helpers
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %0t %s", $time, msg);
      end
   endtask
   task automatic final_report;
      if (errors == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask
   // Bounded wait for the controller to put the request on the lines
   task automatic apply(input logic [5:0] w);
      int i;
      want = w;
      for (i = 0; i < 40 && line_n !== ~w; i++) cyc(1);
      if (line_n !== ~w) begin
         errors++;
         $display("ERROR %0t lines stuck", $time);
         final_report();
      end
   endtask
   // ==========
   // Scenarios
   task automatic t_status;
      int k;
      chk(link, 1, "link");
      for (k = 0; k < 8; k++) begin
         {busy_ind, pass_set, error_set} = k[2:0];
         cyc(2);
         chk({busy, pass, err}, k[2:0], "status");
      end
   endtask
   task automatic t_std;
      int k;
      chk(menu, 1, "menu std");
      for (k = 0; k < 3; k++) begin
         apply(6'h01 << k);
         cyc(QC);
         chk({bn, be, bc}, 0, "early");
         cyc(4);
         chk({bn, be, bc}, 8'h01 << k, "button");
         apply(6'h00);
         cyc(14);
         chk({bn, be, bc}, 0, "release");
      end
   endtask
   task automatic t_bank;
      int a;
      mode = RCP_MODE_BANK;
      cyc(2);
      chk(menu, 0, "menu bank");
      for (a = 7; a >= 0; a--) begin
         apply({3'h0, ~a[2:0]});
         cyc(14);
         chk(area, a[2:0], "area");
         chk({bn, be, bc}, 0, "bank buttons");
      end
      mode = RCP_MODE_STANDARD;
      apply(6'h00);
      cyc(14);
      chk(area, 0, "area hold");
   endtask
   task automatic t_events;
      int k, c, n;
      for (k = 3; k < 5; k++) begin
         apply(6'h01 << k);
         n = 0;
         for (c = 0; c < 20; c++) begin
            cyc(1);
            n += ((k == 3 ? vs : as) === 1'b1);
         end
         chk(n, 1, "pulse count");
         apply(6'h00);
         cyc(14);
      end
   endtask
   task automatic t_clear;
      {pass_set, error_set} = 2'h3;
      apply(6'h20);
      cyc(14);
      chk({pass, err}, 0, "clear");
      apply(6'h00);
      cyc(14);
      chk({pass, err}, 2'h3, "after clear");
   endtask
   task automatic t_reset;
      rstn_i = 1'b0;
      #1;
      chk({link, pass, menu, area}, 8'h08, "in reset");
      cyc(2);
      rstn_i = 1'b1;
      cyc(1);
      chk({link, pass, err}, 3'h7, "after reset");
   endtask
   // Main sequence
   initial begin
      cyc(16);
      rstn_i = 1'b1;
      cyc(2);
      t_status();
      t_std();
      t_bank();
      t_events();
      t_clear();
      t_reset();
      final_report();
   end
endmodule // rcp_remote_port_tb
`default_nettype wire
